/* design/mdc_core.sv */
// Eight-channel DMA transfer engine between peripheral registers and DMA RAM.
// Assumes peripherals and RAM answer a read one cycle after the read strobe.
// Summary of operation
// - Eight channels, each with own state.
// - Channel copies RAM-to-peripheral or peripheral-to-RAM.
// - Own RAM and peripheral buses, CPU untouched.
// - Interrupt at block end, or at half.
// - Byte or word; one-shot or repeating blocks.
// - Post-increment, fixed, or peripheral-indirect RAM addressing.
// - Fixed channel priority, never rotating.
// - Start by software force or selected source.
// - Ping-pong alternates start addresses per block.
// - Interrupt and timer triggers carry no address.
// - Capture units read 0x0140 and 0x0144.
// - Compare one writes 0x0182, secondary 0x0180.
// - Compare two writes 0x0188, secondary 0x0186.
// - First SPI uses 0x0248 both ways.
// - Second SPI uses 0x0268 both ways.
// - First UART reads 0x0226, writes 0x0224.
// - Second UART reads 0x0236, writes fixed address.
// - Converter results read from 0x0300.
// - CAN reads 0x0440, writes 0x0442.
// - Parallel port uses 0x0608 both ways.
// - Codec reads 0x0290, writes 0x0298.
// - Audio right writes 0x03F6, left fixed.
// - Direction bit picks way; enable gates channel.
// - Mode field: continuous/one-shot, ping-pong or not.
// - Force bit cleared only by hardware.
// - Start-address readback shows current pointer.
`timescale 1ns/10ps
`default_nettype none
module mdc_core (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] channel_on,
    input wire logic [7:0] byte_size,
    input wire logic [7:0] ram_to_per,
    input wire logic [7:0] half_notify,
    input wire logic [7:0][1:0] addr_mode,
    input wire logic [7:0][1:0] op_mode,
    input wire logic [7:0][6:0] request_source_select,
    input wire logic [7:0] force_set,
    input wire logic [7:0][15:0] primary_ram_start,
    input wire logic [7:0][15:0] secondary_ram_start,
    input wire logic [7:0][15:0] peripheral_target_address,
    input wire logic [7:0][9:0] transfer_count,
    input wire logic [127:0] irq_src,
    input wire logic [15:0] periph_ram_offset,
    output logic [15:0] ram_addr,
    output logic ram_rd,
    output logic ram_wr,
    output logic ram_byte,
    output logic [15:0] ram_wdata,
    input wire logic [15:0] ram_rdata,
    output logic [15:0] per_addr,
    output logic per_rd,
    output logic per_wr,
    output logic [15:0] per_wdata,
    input wire logic [15:0] per_rdata,
    input wire logic write_stall,
    output logic [7:0] block_irq,
    output logic [7:0] force_pending,
    output logic [7:0][15:0] ram_pointer,
    output logic [7:0] buffer_select,
    output logic [7:0] channel_halted,
    output logic busy,
    output logic [2:0] grant_channel
);
    typedef struct packed {
        mdc_pkg::mdc_state_t st;
        logic [2:0] ch;
        logic [7:0][15:0] ptr;
        logic [7:0][9:0] cnt;
        logic [7:0] pp;
        logic [7:0] req;
        logic [7:0] frc;
        logic [7:0] halt;
        logic [7:0] irq;
        logic [7:0] on_prev;
        logic [15:0] data;
        logic [15:0] ram_addr;
        logic [15:0] per_addr;
        logic [15:0] wdata;
        logic ram_rd;
        logic ram_wr;
        logic per_rd;
        logic per_wr;
        logic bsize;
    } mdc_core_state_t;

    mdc_core_state_t s_q;
    mdc_core_state_t s_d;
    mdc_fifo_if #(.W(mdc_pkg::DW)) fq ();

    // Default peripheral data address for a source code and direction.
    function automatic logic [15:0] table_addr(input logic [6:0] code, input logic to_per);
        logic [15:0] a;
        a = mdc_pkg::ADR_NONE;
        unique case (code)
            mdc_pkg::SRC_CAPTURE1: a = to_per ? mdc_pkg::ADR_NONE : mdc_pkg::ADR_CAPTURE1;
            mdc_pkg::SRC_CAPTURE2: a = to_per ? mdc_pkg::ADR_NONE : mdc_pkg::ADR_CAPTURE2;
            mdc_pkg::SRC_COMPARE1: a = to_per ? mdc_pkg::ADR_CMP1_PRI : mdc_pkg::ADR_NONE;
            mdc_pkg::SRC_COMPARE2: a = to_per ? mdc_pkg::ADR_CMP2_PRI : mdc_pkg::ADR_NONE;
            mdc_pkg::SRC_SPI_A: a = mdc_pkg::ADR_SPI_A;
            mdc_pkg::SRC_SPI_B: a = mdc_pkg::ADR_SPI_B;
            mdc_pkg::SRC_UART_A_RX: a = to_per ? mdc_pkg::ADR_NONE : mdc_pkg::ADR_UART_A_RX;
            mdc_pkg::SRC_UART_A_TX: a = to_per ? mdc_pkg::ADR_UART_A_TX : mdc_pkg::ADR_NONE;
            mdc_pkg::SRC_UART_B_RX: a = to_per ? mdc_pkg::ADR_NONE : mdc_pkg::ADR_UART_B_RX;
            mdc_pkg::SRC_UART_B_TX: a = to_per ? mdc_pkg::ADR_UART_B_TX : mdc_pkg::ADR_NONE;
            mdc_pkg::SRC_ADC: a = to_per ? mdc_pkg::ADR_NONE : mdc_pkg::ADR_ADC;
            mdc_pkg::SRC_CAN_RX: a = to_per ? mdc_pkg::ADR_NONE : mdc_pkg::ADR_CAN_RX;
            mdc_pkg::SRC_CAN_TX: a = to_per ? mdc_pkg::ADR_CAN_TX : mdc_pkg::ADR_NONE;
            mdc_pkg::SRC_PAR_PORT: a = mdc_pkg::ADR_PAR_PORT;
            mdc_pkg::SRC_CODEC: a = to_per ? mdc_pkg::ADR_CODEC_TX : mdc_pkg::ADR_CODEC_RX;
            mdc_pkg::SRC_AUDIO_R: a = to_per ? mdc_pkg::ADR_AUDIO_R : mdc_pkg::ADR_NONE;
            mdc_pkg::SRC_AUDIO_L: a = to_per ? mdc_pkg::ADR_AUDIO_L : mdc_pkg::ADR_NONE;
            default: a = mdc_pkg::ADR_NONE;
        endcase
        return a;
    endfunction

    // A nonzero programmed address wins, which also reaches secondary compare slots.
    function automatic logic [15:0] per_target(input logic [6:0] code, input logic to_per,
                                               input logic [15:0] pad);
        logic [15:0] a;
        a = (pad != mdc_pkg::ADR_NONE) ? pad : table_addr(code, to_per);
        return a;
    endfunction

    // Lowest set bit of a request vector.
    function automatic logic [2:0] lowest(input logic [7:0] v);
        logic [2:0] idx;
        idx = '0;
        for (int i = mdc_pkg::NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    logic [7:0] pending;
    logic [7:0] src_hit;
    logic [2:0] c;
    logic last_elem;
    logic half_elem;
    logic next_pp;
    logic [15:0] step;
    logic ping;
    logic one_shot;

    genvar g;
    generate
        for (g = 0; g < mdc_pkg::NCH; g++) begin : g_src
            assign src_hit[g] = irq_src[request_source_select[g]];
            assign pending[g] = channel_on[g] && s_q.on_prev[g] && !s_q.halt[g]
                && (s_q.req[g] || s_q.frc[g]);
        end
    endgenerate

    assign c = s_q.ch;
    assign ping = op_mode[c][mdc_pkg::MODE_PINGPONG_BIT];
    assign one_shot = op_mode[c][mdc_pkg::MODE_ONESHOT_BIT];
    assign last_elem = (s_q.cnt[c] == transfer_count[c]);
    assign half_elem = (s_q.cnt[c] == (transfer_count[c] >> 1));
    assign next_pp = ping ? !s_q.pp[c] : s_q.pp[c];
    assign step = byte_size[c] ? mdc_pkg::STEP_BYTE : mdc_pkg::STEP_WORD;

    assign fq.push_valid = (s_q.st == mdc_pkg::ST_PUSH);
    assign fq.push_data = s_q.data;
    // Target stalls back up into the FIFO and hold the engine
    assign fq.pop_ready = (s_q.st == mdc_pkg::ST_WRITE) && !write_stall;

    always_comb begin
        s_d = s_q;
        s_d.irq = '0;
        s_d.ram_rd = 1'b0;
        s_d.ram_wr = 1'b0;
        s_d.per_rd = 1'b0;
        s_d.per_wr = 1'b0;
        s_d.on_prev = channel_on;
        for (int i = 0; i < mdc_pkg::NCH; i++) begin
            if (channel_on[i] && !s_q.on_prev[i]) begin
                s_d.ptr[i] = primary_ram_start[i];
                s_d.cnt[i] = '0;
                s_d.pp[i] = 1'b0;
                s_d.halt[i] = 1'b0;
            end
            if (!channel_on[i]) begin
                s_d.req[i] = 1'b0;
            end
        end
        unique case (s_q.st)
            mdc_pkg::ST_IDLE: begin
                if (pending != '0) begin
                    s_d.ch = lowest(pending);
                    s_d.bsize = byte_size[lowest(pending)];
                    s_d.per_addr = per_target(request_source_select[lowest(pending)],
                        ram_to_per[lowest(pending)], peripheral_target_address[lowest(pending)]);
                    if (addr_mode[lowest(pending)][mdc_pkg::AMODE_PERIPH_BIT]) begin
                        s_d.ram_addr = (s_q.pp[lowest(pending)] ? secondary_ram_start[lowest(pending)]
                            : primary_ram_start[lowest(pending)]) + periph_ram_offset;
                    end else begin
                        s_d.ram_addr = s_q.ptr[lowest(pending)];
                    end
                    if (ram_to_per[lowest(pending)] == mdc_pkg::DIR_RAM_TO_PER) begin
                        s_d.ram_rd = 1'b1;
                    end else begin
                        s_d.per_rd = 1'b1;
                    end
                    s_d.st = mdc_pkg::ST_READ;
                end
            end
            mdc_pkg::ST_READ: begin
                s_d.st = mdc_pkg::ST_CAP;
            end
            mdc_pkg::ST_CAP: begin
                if (ram_to_per[c] == mdc_pkg::DIR_RAM_TO_PER) begin
                    s_d.data = s_q.bsize ? {mdc_pkg::BYTE_PAD, ram_rdata[7:0]} : ram_rdata;
                end else begin
                    s_d.data = s_q.bsize ? {mdc_pkg::BYTE_PAD, per_rdata[7:0]} : per_rdata;
                end
                s_d.st = mdc_pkg::ST_PUSH;
            end
            mdc_pkg::ST_PUSH: begin
                if (fq.push_ready) begin
                    s_d.st = mdc_pkg::ST_WRITE;
                end
            end
            mdc_pkg::ST_WRITE: begin
                if (fq.pop_valid && fq.pop_ready) begin
                    s_d.wdata = fq.pop_data;
                    if (ram_to_per[c] == mdc_pkg::DIR_RAM_TO_PER) begin
                        s_d.per_wr = 1'b1;
                    end else begin
                        s_d.ram_wr = 1'b1;
                    end
                    s_d.st = mdc_pkg::ST_DONE;
                end
            end
            mdc_pkg::ST_DONE: begin
                s_d.frc[c] = 1'b0;
                s_d.req[c] = 1'b0;
                if (last_elem) begin
                    s_d.cnt[c] = '0;
                    s_d.irq[c] = !half_notify[c];
                    s_d.pp[c] = next_pp;
                    s_d.ptr[c] = next_pp ? secondary_ram_start[c] : primary_ram_start[c];
                    if (one_shot && (!ping || s_q.pp[c])) begin
                        s_d.halt[c] = 1'b1;
                    end
                end else begin
                    s_d.cnt[c] = s_q.cnt[c] + 1'b1;
                    if (addr_mode[c] == mdc_pkg::AMODE_POSTINC) begin
                        s_d.ptr[c] = s_q.ptr[c] + step;
                    end
                end
                if (half_notify[c] && half_elem) begin
                    s_d.irq[c] = 1'b1;
                end
                s_d.st = mdc_pkg::ST_IDLE;
            end
            default: begin
                s_d.st = mdc_pkg::ST_IDLE;
            end
        endcase
        // New events win over the clears above
        for (int i = 0; i < mdc_pkg::NCH; i++) begin
            if (channel_on[i] && src_hit[i]) begin
                s_d.req[i] = 1'b1;
            end
            if (force_set[i]) begin
                s_d.frc[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    mdc_fifo #(
        .W(mdc_pkg::DW),
        .DEPTH(mdc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .port(fq.fifo)
    );

    assign ram_addr = s_q.ram_addr;
    assign ram_rd = s_q.ram_rd;
    assign ram_wr = s_q.ram_wr;
    assign ram_byte = s_q.bsize;
    assign ram_wdata = s_q.wdata;
    assign per_addr = s_q.per_addr;
    assign per_rd = s_q.per_rd;
    assign per_wr = s_q.per_wr;
    assign per_wdata = s_q.wdata;
    assign block_irq = s_q.irq;
    assign force_pending = s_q.frc;
    assign ram_pointer = s_q.ptr;
    assign buffer_select = s_q.pp;
    assign channel_halted = s_q.halt;
    assign busy = (s_q.st != mdc_pkg::ST_IDLE);
    assign grant_channel = s_q.ch;
endmodule // mdc_core
`default_nettype wire

/* design/mdc_pkg.sv */
// Shared constants of the eight-channel DMA controller.
// Assumes one clock domain; the peripheral table holds default data addresses.
package mdc_pkg;
    localparam int NCH = 8;
    localparam int CHW = 3;
    localparam int SELW = 7;
    localparam int AW = 16;
    localparam int DW = 16;
    localparam int CNTW = 10;
    localparam int NSRC = 128;
    localparam int FIFO_DEPTH = 4;

    // Request source codes
    localparam logic [6:0] SRC_EXT_INT = 7'h00;
    localparam logic [6:0] SRC_CAPTURE1 = 7'h01;
    localparam logic [6:0] SRC_COMPARE1 = 7'h02;
    localparam logic [6:0] SRC_CAPTURE2 = 7'h05;
    localparam logic [6:0] SRC_COMPARE2 = 7'h06;
    localparam logic [6:0] SRC_TIMER_A = 7'h07;
    localparam logic [6:0] SRC_TIMER_B = 7'h08;
    localparam logic [6:0] SRC_SPI_A = 7'h0a;
    localparam logic [6:0] SRC_UART_A_RX = 7'h0b;
    localparam logic [6:0] SRC_UART_A_TX = 7'h0c;
    localparam logic [6:0] SRC_ADC = 7'h0d;
    localparam logic [6:0] SRC_UART_B_RX = 7'h1e;
    localparam logic [6:0] SRC_UART_B_TX = 7'h1f;
    localparam logic [6:0] SRC_SPI_B = 7'h21;
    localparam logic [6:0] SRC_CAN_RX = 7'h22;
    localparam logic [6:0] SRC_PAR_PORT = 7'h2d;
    localparam logic [6:0] SRC_CODEC = 7'h3c;
    localparam logic [6:0] SRC_CAN_TX = 7'h46;
    localparam logic [6:0] SRC_AUDIO_R = 7'h4e;
    localparam logic [6:0] SRC_AUDIO_L = 7'h4f;

    // Peripheral data addresses
    localparam logic [15:0] ADR_CAPTURE1 = 16'h0140;
    localparam logic [15:0] ADR_CAPTURE2 = 16'h0144;
    localparam logic [15:0] ADR_CMP1_PRI = 16'h0182;
    localparam logic [15:0] ADR_CMP1_SEC = 16'h0180;
    localparam logic [15:0] ADR_CMP2_PRI = 16'h0188;
    localparam logic [15:0] ADR_CMP2_SEC = 16'h0186;
    localparam logic [15:0] ADR_SPI_A = 16'h0248;
    localparam logic [15:0] ADR_SPI_B = 16'h0268;
    localparam logic [15:0] ADR_UART_A_RX = 16'h0226;
    localparam logic [15:0] ADR_UART_A_TX = 16'h0224;
    localparam logic [15:0] ADR_UART_B_RX = 16'h0236;
    localparam logic [15:0] ADR_UART_B_TX = 16'h0234;
    localparam logic [15:0] ADR_ADC = 16'h0300;
    localparam logic [15:0] ADR_CAN_RX = 16'h0440;
    localparam logic [15:0] ADR_CAN_TX = 16'h0442;
    localparam logic [15:0] ADR_PAR_PORT = 16'h0608;
    localparam logic [15:0] ADR_CODEC_RX = 16'h0290;
    localparam logic [15:0] ADR_CODEC_TX = 16'h0298;
    localparam logic [15:0] ADR_AUDIO_R = 16'h03f6;
    localparam logic [15:0] ADR_AUDIO_L = 16'h03f8;
    localparam logic [15:0] ADR_NONE = 16'h0000;

    // Mode fields
    localparam int MODE_ONESHOT_BIT = 0;
    localparam int MODE_PINGPONG_BIT = 1;
    localparam logic [1:0] AMODE_POSTINC = 2'h0;
    localparam int AMODE_PERIPH_BIT = 1;
    localparam logic DIR_RAM_TO_PER = 1'b1;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [7:0] BYTE_PAD = 8'h00;

    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_CAP, ST_PUSH, ST_WRITE, ST_DONE} mdc_state_t;
endpackage

/* design/mdc_fifo_if.sv */
// Handshake bundle between the transfer engine and its data FIFO.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface mdc_fifo_if #(parameter int W = 16);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport core (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
    modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

/* design/mdc_fifo.sv */
// Small flip-flop FIFO holding data between source read and target write.
// Assumes synchronous active-high reset on core_clk.
`timescale 1ns/10ps
`default_nettype none
module mdc_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    mdc_fifo_if.fifo port
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] level;
    } mdc_fifo_state_t;

    mdc_fifo_state_t s_q;
    mdc_fifo_state_t s_d;
    logic do_push;
    logic do_pop;

    assign port.push_ready = (s_q.level != (PW+1)'(DEPTH));
    assign port.pop_valid = (s_q.level != '0);
    assign port.pop_data = s_q.mem[s_q.rd];
    assign do_push = port.push_valid && port.push_ready;
    assign do_pop = port.pop_valid && port.pop_ready;

    always_comb begin
        s_d = s_q;
        if (do_push) begin
            s_d.mem[s_q.wr] = port.push_data;
            s_d.wr = (s_q.wr == PW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
        end
        if (do_pop) begin
            s_d.rd = (s_q.rd == PW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
        end
        if (do_push && !do_pop) begin
            s_d.level = s_q.level + 1'b1;
        end else if (do_pop && !do_push) begin
            s_d.level = s_q.level - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // mdc_fifo
`default_nettype wire

/* bench/mdc_core_properties.sv */
// Concurrent checks on the DMA engine's top-level ports.
// Assumes it is bound into mdc_core; one clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module mdc_core_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] channel_on,
    input wire logic [7:0][6:0] request_source_select,
    input wire logic [7:0] force_set,
    input wire logic [7:0][15:0] primary_ram_start,
    input wire logic [7:0][15:0] peripheral_target_address,
    input wire logic ram_rd,
    input wire logic ram_wr,
    input wire logic ram_byte,
    input wire logic [15:0] ram_wdata,
    input wire logic [15:0] per_addr,
    input wire logic per_rd,
    input wire logic per_wr,
    input wire logic [15:0] per_wdata,
    input wire logic write_stall,
    input wire logic [7:0] block_irq,
    input wire logic [7:0] force_pending,
    input wire logic [7:0][15:0] ram_pointer,
    input wire logic [2:0] grant_channel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_one_read; !(ram_rd && per_rd); endproperty
    a_one_read: assert property (p_one_read) else $error("two read strobes at once");
    property p_per_to_ram; per_rd ##1 (!write_stall) [*3] |=> ram_wr; endproperty
    a_per_to_ram: assert property (p_per_to_ram) else $error("no ram write after read");
    property p_ram_to_per; ram_rd ##1 (!write_stall) [*3] |=> per_wr; endproperty
    a_ram_to_per: assert property (p_ram_to_per) else $error("no peripheral write");
    property p_uart_rx; per_rd && request_source_select[grant_channel] == mdc_pkg::SRC_UART_A_RX
        && peripheral_target_address[grant_channel] == 16'h0000
        |-> per_addr == mdc_pkg::ADR_UART_A_RX; endproperty
    a_uart_rx: assert property (p_uart_rx) else $error("wrong receive address");
    property p_byte_pad; (ram_wr || per_wr) && ram_byte
        |-> ram_wdata[15:8] == 8'h00 && per_wdata[15:8] == 8'h00; endproperty
    a_byte_pad: assert property (p_byte_pad) else $error("byte data upper half not zero");
    property p_irq_pulse; block_irq != 8'h00 |=> block_irq == 8'h00; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("block interrupt held");
    property p_force_src; $rose(force_pending[1]) |-> $past(force_set[1]); endproperty
    a_force_src: assert property (p_force_src) else $error("force set without request");
    property p_ptr_load; $rose(channel_on[5]) |=> ram_pointer[5] == primary_ram_start[5];
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not reloaded");
    property p_granted_on; ram_rd || per_rd |-> channel_on[grant_channel]; endproperty
    a_granted_on: assert property (p_granted_on) else $error("disabled channel served");
endmodule // mdc_core_properties
bind mdc_core mdc_core_properties u_mdc_core_properties (.*);
`default_nettype wire

/* bench/mdc_far_model.sv */
// Peripheral registers and DMA RAM seen from the engine, plus a write log.
// Assumes read data is wanted one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module mdc_far_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] ram_addr,
    input wire logic ram_rd,
    input wire logic ram_wr,
    input wire logic [15:0] ram_wdata,
    input wire logic [15:0] per_addr,
    input wire logic per_rd,
    input wire logic per_wr,
    input wire logic [15:0] per_wdata,
    input wire logic [7:0] block_irq,
    output var logic [15:0] ram_rdata,
    output var logic [15:0] per_rdata,
    output var logic [15:0] rd_a,
    output var logic [15:0] wr_a,
    output var logic [15:0] wr_d,
    output var logic wr_p,
    output var logic [7:0] wr_n,
    output var logic [7:0][3:0] irq_cnt
);
    initial begin
        ram_rdata = 16'h0000;
        per_rdata = 16'h0000;
    end
    always @(posedge core_clk) begin
        // Outside the answer cycle the data drifts, so a late sample shows up
        ram_rdata <= ram_rd ? ram_addr ^ 16'h3c3c : ~ram_rdata;
        per_rdata <= per_rd ? per_addr ^ 16'h5a5a : ~per_rdata;
        if (rst) begin
            wr_n <= 8'h00;
            irq_cnt <= '0;
        end else begin
            if (ram_rd) rd_a <= ram_addr;
            if (per_rd) rd_a <= per_addr;
            if (ram_wr || per_wr) begin
                wr_n <= wr_n + 8'h01;
                wr_p <= per_wr;
                wr_a <= per_wr ? per_addr : ram_addr;
                wr_d <= per_wr ? per_wdata : ram_wdata;
            end
            for (int i = 0; i < 8; i++) irq_cnt[i] <= irq_cnt[i] + 4'(block_irq[i]);
        end
    end
endmodule // mdc_far_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the DMA engine: requests in, logged bus traffic out.
// Assumes mdc_core, its checker and mdc_far_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] channel_on = '0, byte_size = '0, ram_to_per = '0, half_notify = 8'h40;
    logic [7:0] force_set = '0;
    logic [7:0][1:0] addr_mode = '0, op_mode = '0;
    logic [7:0][6:0] request_source_select = '0;
    logic [7:0][15:0] primary_ram_start = '0, secondary_ram_start = '0;
    logic [7:0][15:0] peripheral_target_address = '0, ram_pointer;
    logic [7:0][9:0] transfer_count = '0;
    logic [127:0] irq_src = '0;
    logic [15:0] periph_ram_offset = 16'h0010, ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata;
    logic [15:0] per_rdata, rd_a, wr_a, wr_d;
    logic write_stall = 1'b0, ram_rd, ram_wr, ram_byte, per_rd, per_wr, busy, wr_p;
    logic [7:0] block_irq, force_pending, buffer_select, channel_halted, wr_n;
    logic [2:0] grant_channel;
    logic [7:0][3:0] irq_cnt;
    int err_total = 0, total_checks = 0;
    // Direction nibble, source code byte, expected peripheral address
    logic [27:0] tbl [24] = '{28'h0010140, 28'h0050144, 28'h00a0248, 28'h00b0226, 28'h00d0300,
        28'h01e0236, 28'h0210268, 28'h0220440, 28'h02d0608, 28'h03c0290, 28'h0000000,
        28'h0070000, 28'h0080000, 28'h1020182, 28'h1060188, 28'h10a0248, 28'h10c0224,
        28'h11f0234, 28'h1210268, 28'h12d0608, 28'h13c0298, 28'h1460442, 28'h14e03f6,
        28'h14f03f8};
    mdc_core u_mdc_core (.*);
    mdc_far_model u_mdc_far_model (.*);
    always #10 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cfg(input int c, input logic d, input logic b, input logic [1:0] am,
        input logic [1:0] om, input logic [6:0] s, input logic [15:0] sta,
        input logic [15:0] stb, input logic [15:0] pta, input logic [9:0] n);
        @(posedge core_clk);
        channel_on[c] <= 1'b0;
        @(posedge core_clk);
        ram_to_per[c] <= d;
        byte_size[c] <= b;
        addr_mode[c] <= am;
        op_mode[c] <= om;
        request_source_select[c] <= s;
        primary_ram_start[c] <= sta;
        secondary_ram_start[c] <= stb;
        peripheral_target_address[c] <= pta;
        transfer_count[c] <= n;
        channel_on[c] <= 1'b1;
    endtask
    task automatic fire(input int src, input int fch);
        @(posedge core_clk);
        if (src >= 0) irq_src[src] <= 1'b1;
        if (fch >= 0) force_set[fch] <= 1'b1;
        @(posedge core_clk);
        irq_src <= '0;
        force_set <= '0;
    endtask
    task automatic wait_wr(input bit exp);
        logic [7:0] n0;
        n0 = wr_n;
        repeat (40) begin
            @(negedge core_clk);
            if (wr_n !== n0) break;
        end
        chk("write_seen", 16'(exp), 16'(wr_n !== n0));
        repeat (3) @(negedge core_clk);
    endtask
    task automatic xfer(input int src, input int fch, input bit exp);
        fire(src, fch);
        wait_wr(exp);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        // One-shot word block of two elements from the first receiver
        cfg(0, 0, 0, 2'h0, 2'h1, 7'h0b, 16'h1000, 16'h0000, 16'h0000, 10'h001);
        xfer(11, -1, 1);
        chk("rd_a", 16'h0226, rd_a);
        chk("wr_a", 16'h1000, wr_a);
        chk("wr_d", 16'h587c, wr_d);
        chk("ptr0", 16'h1002, ram_pointer[0]);
        chk("irq0", 16'h0000, 16'(irq_cnt[0]));
        xfer(11, -1, 1);
        chk("wr_a", 16'h1002, wr_a);
        chk("irq0", 16'h0001, 16'(irq_cnt[0]));
        chk("halt0", 16'h0001, 16'(channel_halted[0]));
        xfer(11, -1, 0);
        // Forced byte sends from a fixed RAM address
        cfg(1, 1, 1, 2'h1, 2'h0, 7'h0c, 16'h2000, 16'h0000, 16'h0000, 10'h000);
        repeat (2) begin
            xfer(-1, 1, 1);
            chk("rd_a", 16'h2000, rd_a);
            chk("wr_a", 16'h0224, wr_a);
            chk("wr_d", 16'h003c, wr_d);
            chk("wr_p", 16'h0001, 16'(wr_p));
            chk("force1", 16'h0000, 16'(force_pending[1]));
        end
        chk("irq1", 16'h0002, 16'(irq_cnt[1]));
        // Two channels on one source: the lower one is served first
        cfg(2, 0, 0, 2'h0, 2'h0, 7'h0d, 16'h3000, 16'h0000, 16'h0000, 10'h000);
        cfg(3, 0, 0, 2'h0, 2'h0, 7'h0d, 16'h4000, 16'h0000, 16'h0000, 10'h000);
        fire(13, -1);
        wait_wr(1);
        chk("wr_a", 16'h3000, wr_a);
        wait_wr(1);
        chk("wr_a", 16'h4000, wr_a);
        chk("rd_a", 16'h0300, rd_a);
        chk("grant", 16'h0003, 16'(grant_channel));
        chk("busy", 16'h0000, 16'(busy));
        cfg(4, 0, 0, 2'h0, 2'h2, 7'h0a, 16'h5000, 16'h6000, 16'h0000, 10'h000);
        xfer(10, -1, 1);
        chk("wr_a", 16'h5000, wr_a);
        chk("bufsel4", 16'h0001, 16'(buffer_select[4]));
        xfer(10, -1, 1);
        chk("wr_a", 16'h6000, wr_a);
        cfg(6, 0, 0, 2'h1, 2'h0, 7'h21, 16'h7800, 16'h0000, 16'h0000, 10'h003);
        for (int k = 1; k < 5; k++) begin
            xfer(33, -1, 1);
            chk("irq6", 16'(k > 1), 16'(irq_cnt[6]));
        end
        @(posedge core_clk);
        channel_on <= 8'h00;
        // Every source code against its fixed peripheral address
        foreach (tbl[i]) begin
            cfg(5, tbl[i][24], 0, 2'h0, 2'h0, tbl[i][22:16], 16'h7000, 16'h0000, 16'h0000, 10'h0);
            xfer(int'(tbl[i][22:16]), -1, 1);
            chk("per_addr", tbl[i][15:0], tbl[i][24] ? wr_a : rd_a);
        end
        cfg(5, 1, 0, 2'h2, 2'h0, 7'h02, 16'h7000, 16'h0000, 16'h0180, 10'h000);
        xfer(2, -1, 1);
        chk("per_addr", 16'h0180, wr_a);
        chk("rd_a", 16'h7010, rd_a);
        give_verdict;
    end
    initial begin
        // The sequence needs about five hundred cycles; far beyond that is a hang
        repeat (20000) @(posedge core_clk);
        err_total++;
        give_verdict;
    end
endmodule // tb
`default_nettype wire
